// ===== hw/psp_device.sv
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module psp_device (
	input wire logic clock,
	input wire logic sys_rst,
	psp_link_if.device link,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata
);
	// ==========================================
	// Registers
	logic [7:0] data_port_out_latch;
	logic [7:0] data_port_direction;
	logic [2:0] strobe_port_out_latch;
	logic [2:0] strobe_dir;
	logic [2:0] analog_pin_config;
	logic slave_mode_select;
	logic input_full_flag;
	logic output_full_flag;
	logic input_overflow_flag;
	logic [7:0] input_byte;
	logic [2:0] strobe_meta;
	logic [2:0] strobe_sync;
	logic [7:0] data_meta;
	logic [7:0] data_sync;
	logic read_active;
	logic write_active;
	// ==========================================
	// Decode
	wire cpu_wr_data = wr_en && addr == psp_pkg::REG_DATA_PINS;
	wire cpu_rd_data = rd_en && addr == psp_pkg::REG_DATA_PINS;
	wire cpu_wr_status = wr_en && addr == psp_pkg::REG_STROBE_DIR_STATUS;
	wire cpu_wr_latch = wr_en && addr == psp_pkg::REG_DATA_LATCH;
	wire cpu_wr_dir = wr_en && addr == psp_pkg::REG_DATA_DIR;
	wire cpu_wr_strobe_latch = wr_en && (addr == psp_pkg::REG_STROBE_PINS || addr == psp_pkg::REG_STROBE_LATCH);
	wire cpu_wr_analog = wr_en && addr == psp_pkg::REG_ANALOG_CONFIG;
	// Analog pins are muxed to the converter; a clear config bit means digital
	wire [2:0] digital_pins = ~analog_pin_config;
	wire [2:0] strobe_pins = strobe_sync & digital_pins;
	// A low strobe only counts while the port is in slave mode and selected
	// An analog select pin reads low, so it must never count as selected
	wire sel = slave_mode_select && digital_pins[2] && !strobe_pins[2];
	wire rd_low = sel && !strobe_pins[0] && digital_pins[0];
	wire wr_low = sel && !strobe_pins[1] && digital_pins[1];
	wire host_write = wr_low && !write_active;
	// Output full clears only once the read strobe has ended and the host has the byte
	wire host_read_end = read_active && !rd_low;
	wire [7:0] status_word = {input_full_flag, output_full_flag, input_overflow_flag,
		slave_mode_select, 1'b0, strobe_dir};
	// In slave mode the pin register reads the byte the host left behind
	wire [7:0] data_read = slave_mode_select ? input_byte : data_sync;
	wire [7:0] read_mux = addr == psp_pkg::REG_DATA_PINS ? data_read :
		addr == psp_pkg::REG_DATA_LATCH ? data_port_out_latch :
		addr == psp_pkg::REG_DATA_DIR ? data_port_direction :
		addr == psp_pkg::REG_STROBE_PINS ? {5'h00, strobe_pins} :
		addr == psp_pkg::REG_STROBE_LATCH ? {5'h00, strobe_port_out_latch} :
		addr == psp_pkg::REG_STROBE_DIR_STATUS ? status_word :
		addr == psp_pkg::REG_ANALOG_CONFIG ? {5'h00, analog_pin_config} : 8'h00;
	// ==========================================
	// Next flag values
	// Host write wins over a CPU read in the same cycle
	wire next_input_full = host_write || (input_full_flag && !cpu_rd_data);
	// A CPU read in the same cycle empties the buffer, so that write is no overflow
	wire overflow_set = host_write && input_full_flag && !cpu_rd_data;
	wire overflow_clear = cpu_wr_status && !wdata[psp_pkg::BIT_OVERFLOW];
	wire next_overflow = overflow_set || (input_overflow_flag && !overflow_clear);
	wire obf_set = cpu_wr_data && slave_mode_select;
	wire next_output_full = obf_set || (output_full_flag && !host_read_end);
	// ==========================================
	// Per-pin drive enables
	wire [7:0] next_data_oe_n;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_data_oe
			// Slave mode drives the data bus only while the host reads
			assign next_data_oe_n[gi] = slave_mode_select ? !rd_low : data_port_direction[gi];
		end
	endgenerate
	// ==========================================
	// Synchronisers
	// Data passes the same two stages as the strobes so both line up
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strobe_meta <= 3'h7;
			strobe_sync <= 3'h7;
		end else begin
			strobe_meta <= link.strobe_bus;
			strobe_sync <= strobe_meta;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_meta <= 8'h00;
			data_sync <= 8'h00;
		end else begin
			data_meta <= link.data_bus;
			data_sync <= data_meta;
		end
	end
	// ==========================================
	// CPU registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else begin
			// Idle read data is zero, not the last value read
			rdata <= rd_en ? read_mux : 8'h00;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_port_out_latch <= psp_pkg::LATCH_RESET;
			data_port_direction <= psp_pkg::DATA_DIR_RESET;
		end else begin
			// Port register write lands in the latch in both modes
			if (cpu_wr_data || cpu_wr_latch) data_port_out_latch <= wdata;
			if (cpu_wr_dir) data_port_direction <= wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strobe_port_out_latch <= psp_pkg::LATCH_RESET[2:0];
			strobe_dir <= psp_pkg::STROBE_DIR_RESET;
			slave_mode_select <= 1'b0;
		end else begin
			if (cpu_wr_strobe_latch) strobe_port_out_latch <= wdata[2:0];
			if (cpu_wr_status) strobe_dir <= wdata[2:0];
			if (cpu_wr_status) slave_mode_select <= wdata[psp_pkg::BIT_SLAVE_MODE];
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			analog_pin_config <= psp_pkg::ANALOG_RESET;
		end else if (cpu_wr_analog) begin
			analog_pin_config <= wdata[2:0];
		end
	end
	// ==========================================
	// Slave port flags
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			read_active <= 1'b0;
			write_active <= 1'b0;
		end else begin
			// Remembering the last level makes each strobe count once
			write_active <= wr_low;
			read_active <= rd_low;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			input_byte <= 8'h00;
		end else if (host_write) begin
			input_byte <= data_sync;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			input_full_flag <= 1'b0;
			output_full_flag <= 1'b0;
			input_overflow_flag <= 1'b0;
		end else begin
			input_full_flag <= next_input_full;
			output_full_flag <= next_output_full;
			input_overflow_flag <= next_overflow;
		end
	end
	// ==========================================
	// Pin drivers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			link.data_pins_o <= psp_pkg::LATCH_RESET;
			link.data_pins_oe_n <= psp_pkg::DATA_DIR_RESET;
		end else begin
			link.data_pins_o <= data_port_out_latch;
			link.data_pins_oe_n <= next_data_oe_n;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			link.strobe_pins_o <= psp_pkg::LATCH_RESET[2:0];
			link.strobe_pins_oe_n <= psp_pkg::STROBE_DIR_RESET;
		end else begin
			link.strobe_pins_o <= strobe_port_out_latch;
			link.strobe_pins_oe_n <= strobe_dir;
		end
	end
endmodule

// ===== hw/psp_host.sv
`timescale 1ns/1ps
module psp_host (
	input wire logic clock,
	input wire logic sys_rst,
	psp_link_if.host link,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata
);
	// ==========================================
	// Command decode
	psp_pkg::psp_state_t state;
	psp_pkg::psp_state_t next_state;
	logic is_write;
	logic [7:0] out_byte;
	logic [7:0] in_byte;
	logic [3:0] cnt;
	logic busy;
	wire go = wr_en && addr == psp_pkg::HOST_REG_CTRL && wdata[psp_pkg::BIT_HOST_GO] && !busy;
	wire next_is_write = go ? wdata[psp_pkg::BIT_HOST_WRITE] : is_write;
	wire cnt_done = cnt == psp_pkg::STROBE_CYCLES;
	wire [7:0] read_mux = addr == psp_pkg::HOST_REG_DATA ? in_byte :
		(addr == psp_pkg::HOST_REG_STATUS ? {7'h00, busy} : 8'h00);
	always_comb begin
		next_state = state;
		case (state)
			psp_pkg::PSP_IDLE: if (go) next_state = psp_pkg::PSP_SETUP;
			psp_pkg::PSP_SETUP: next_state = psp_pkg::PSP_STROBE;
			psp_pkg::PSP_STROBE: if (cnt_done) next_state = psp_pkg::PSP_HOLD;
			psp_pkg::PSP_HOLD: next_state = psp_pkg::PSP_IDLE;
			default: next_state = psp_pkg::PSP_IDLE;
		endcase
	end
	// ==========================================
	// Strobe sequencing
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= psp_pkg::PSP_IDLE;
			cnt <= 4'h0;
			busy <= 1'b0;
			is_write <= 1'b0;
			out_byte <= 8'h00;
			in_byte <= 8'h00;
			rdata <= 8'h00;
			link.cs_n <= 1'b1;
			link.rd_n <= 1'b1;
			link.wr_n <= 1'b1;
			link.host_data_oe_n <= 1'b1;
			link.host_data_o <= 8'h00;
		end else begin
			state <= next_state;
			rdata <= rd_en ? read_mux : 8'h00;
			if (wr_en && addr == psp_pkg::HOST_REG_DATA && !busy) begin
				out_byte <= wdata;
			end
			if (go) begin
				busy <= 1'b1;
				is_write <= wdata[psp_pkg::BIT_HOST_WRITE];
			end
			cnt <= (state == psp_pkg::PSP_STROBE) ? cnt + 4'h1 : 4'h0;
			// Select and strobe go low together and stay low for the strobe window
			link.cs_n <= !(next_state == psp_pkg::PSP_STROBE);
			link.wr_n <= !(next_state == psp_pkg::PSP_STROBE && is_write);
			link.rd_n <= !(next_state == psp_pkg::PSP_STROBE && !is_write);
			// Data driven a cycle early so it is settled before the strobe
			link.host_data_oe_n <= !(next_is_write && next_state != psp_pkg::PSP_IDLE);
			link.host_data_o <= out_byte;
			if (state == psp_pkg::PSP_STROBE && cnt_done && !is_write) begin
				in_byte <= link.data_bus;
			end
			if (state == psp_pkg::PSP_HOLD) begin
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== hw/psp_link_if.sv
`timescale 1ns/1ps
interface psp_link_if;
	logic [7:0] data_pins_o;
	logic [7:0] data_pins_oe_n;
	logic [2:0] strobe_pins_o;
	logic [2:0] strobe_pins_oe_n;
	logic [7:0] host_data_o;
	logic host_data_oe_n;
	logic rd_n;
	logic wr_n;
	logic cs_n;
	wire [7:0] data_bus;
	wire [2:0] strobe_bus;
	genvar i;
	// ==========================================
	// Resolve shared wires from the enables
	generate
		for (i = 0; i < 8; i++) begin : g_data
			assign data_bus[i] = !data_pins_oe_n[i] ? data_pins_o[i] :
				(!host_data_oe_n ? host_data_o[i] : 1'b1);
		end
	endgenerate
	assign strobe_bus[0] = !strobe_pins_oe_n[0] ? strobe_pins_o[0] : rd_n;
	assign strobe_bus[1] = !strobe_pins_oe_n[1] ? strobe_pins_o[1] : wr_n;
	assign strobe_bus[2] = !strobe_pins_oe_n[2] ? strobe_pins_o[2] : cs_n;
	modport device (output data_pins_o, output data_pins_oe_n, output strobe_pins_o,
		output strobe_pins_oe_n, input data_bus, input strobe_bus);
	modport host (output host_data_o, output host_data_oe_n, output rd_n, output wr_n,
		output cs_n, input data_bus);
endinterface

// ===== hw/psp_pkg.sv
package psp_pkg;
	// ==========================================
	// Register indices on the CPU port
	localparam logic [2:0] REG_DATA_PINS = 3'h0;
	localparam logic [2:0] REG_DATA_LATCH = 3'h1;
	localparam logic [2:0] REG_DATA_DIR = 3'h2;
	localparam logic [2:0] REG_STROBE_PINS = 3'h3;
	localparam logic [2:0] REG_STROBE_LATCH = 3'h4;
	localparam logic [2:0] REG_STROBE_DIR_STATUS = 3'h5;
	localparam logic [2:0] REG_ANALOG_CONFIG = 3'h6;
	// ==========================================
	// Direction/status fields
	localparam int BIT_INPUT_FULL = 7;
	localparam int BIT_OUTPUT_FULL = 6;
	localparam int BIT_OVERFLOW = 5;
	localparam int BIT_SLAVE_MODE = 4;
	// ==========================================
	// Reset values
	localparam logic [7:0] DATA_DIR_RESET = 8'hFF;
	localparam logic [2:0] STROBE_DIR_RESET = 3'h7;
	localparam logic [2:0] ANALOG_RESET = 3'h7;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	// ==========================================
	// External processor end
	localparam logic [1:0] HOST_REG_CTRL = 2'h0;
	localparam logic [1:0] HOST_REG_DATA = 2'h1;
	localparam logic [1:0] HOST_REG_STATUS = 2'h2;
	localparam int BIT_HOST_GO = 0;
	localparam int BIT_HOST_WRITE = 1;
	localparam logic [3:0] STROBE_CYCLES = 4'h4;
	typedef enum logic [1:0] {
		PSP_IDLE = 2'b00,
		PSP_SETUP = 2'b01,
		PSP_STROBE = 2'b10,
		PSP_HOLD = 2'b11
	} psp_state_t;
endpackage

// ===== verif/psp_bench.sv
`timescale 1ns/1ps
module psp_bench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] d_addr = 3'h0;
	logic [1:0] h_addr = 2'h0;
	logic [7:0] d_wdata = 8'h00;
	logic [7:0] h_wdata = 8'h00;
	logic d_wr = 1'b0;
	logic d_rd = 1'b0;
	logic h_wr = 1'b0;
	logic h_rd = 1'b0;
	logic [7:0] d_rdata;
	logic [7:0] h_rdata;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	psp_link_if link ();
	psp_device i_psp_device (.clock(clock), .sys_rst(sys_rst), .link(link), .addr(d_addr), .wdata(d_wdata),
		.wr_en(d_wr), .rd_en(d_rd), .rdata(d_rdata));
	psp_host i_psp_host (.clock(clock), .sys_rst(sys_rst), .link(link), .addr(h_addr), .wdata(h_wdata),
		.wr_en(h_wr), .rd_en(h_rd), .rdata(h_rdata));
	psp_link_chk i_psp_link_chk (.clock(clock), .sys_rst(sys_rst), .data_pins_oe_n(link.data_pins_oe_n),
		.strobe_pins_oe_n(link.strobe_pins_oe_n), .host_data_oe_n(link.host_data_oe_n), .rd_n(link.rd_n),
		.wr_n(link.wr_n), .cs_n(link.cs_n));
	// ==========================================
	// Clock, timeout and verdict
	initial forever #50 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// ==========================================
	// CPU port cycles, both ends
	task automatic dw(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		d_addr <= a;
		d_wdata <= v;
		d_wr <= 1'b1;
		@(posedge clock);
		d_wr <= 1'b0;
	endtask
	task automatic dr(input logic [2:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		d_addr <= a;
		d_rd <= 1'b1;
		@(posedge clock);
		d_rd <= 1'b0;
		@(negedge clock);
		check(what, exp, d_rdata);
	endtask
	task automatic hw(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock);
		h_addr <= a;
		h_wdata <= v;
		h_wr <= 1'b1;
		@(posedge clock);
		h_wr <= 1'b0;
	endtask
	task automatic hr(input logic [1:0] a, output logic [7:0] v);
		@(posedge clock);
		h_addr <= a;
		h_rd <= 1'b1;
		@(posedge clock);
		h_rd <= 1'b0;
		@(negedge clock);
		v = h_rdata;
	endtask
	// One host access; busy is polled under a bound
	task automatic hx(input logic wr, input logic [7:0] v);
		logic [7:0] s;
		s = 8'h01;
		hw(psp_pkg::HOST_REG_DATA, v);
		hw(psp_pkg::HOST_REG_CTRL, {6'h00, wr, 1'b1});
		for (int i = 0; i < 40 && s[0] !== 1'b0; i++) begin
			hr(psp_pkg::HOST_REG_STATUS, s);
		end
		check("host busy", 8'h00, {7'h00, s[0]});
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h07, "status");
		dr(psp_pkg::REG_STROBE_PINS, 8'h00, "analog pins");
		dr(psp_pkg::REG_DATA_DIR, 8'hFF, "data dir");
		dr(3'h7, 8'h00, "unmapped");
	endtask
	// Analog pins still follow direction but read zero
	task automatic t_gpio();
		dw(psp_pkg::REG_STROBE_LATCH, 8'h05);
		dw(psp_pkg::REG_STROBE_DIR_STATUS, 8'h08);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h00, "bit3");
		check("strobe oe", 8'h00, {5'h00, link.strobe_pins_oe_n});
		dr(psp_pkg::REG_STROBE_PINS, 8'h00, "analog read");
		dw(psp_pkg::REG_ANALOG_CONFIG, 8'h00);
		dr(psp_pkg::REG_STROBE_PINS, 8'h05, "driven pins");
		check("strobe bus", 8'h05, {5'h00, link.strobe_bus});
		dr(psp_pkg::REG_STROBE_LATCH, 8'h05, "latch");
		dw(psp_pkg::REG_DATA_LATCH, 8'h96);
		dw(psp_pkg::REG_DATA_DIR, 8'h00);
		// Pin reads lag a pin change by the two synchroniser stages
		repeat (2) @(posedge clock);
		dr(psp_pkg::REG_DATA_PINS, 8'h96, "data pins");
		check("data bus", 8'h96, link.data_bus);
		dr(psp_pkg::REG_DATA_LATCH, 8'h96, "data latch");
		dw(psp_pkg::REG_DATA_DIR, 8'hFF);
		dw(psp_pkg::REG_STROBE_DIR_STATUS, 8'h07);
		repeat (2) @(posedge clock);
		dr(psp_pkg::REG_STROBE_PINS, 8'h07, "input pins");
	endtask
	task automatic t_refuse();
		hx(1'b1, 8'hC3);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h07, "port mode write");
		dw(psp_pkg::REG_ANALOG_CONFIG, 8'h04);
		dw(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17);
		hx(1'b1, 8'hC3);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17, "analog select write");
	endtask
	task automatic t_write();
		dw(psp_pkg::REG_ANALOG_CONFIG, 8'h00);
		dw(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17);
		hx(1'b1, 8'hA5);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h97, "input full");
		hx(1'b1, 8'h3C);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'hB7, "overflow");
		dr(psp_pkg::REG_DATA_PINS, 8'h3C, "slave byte");
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h37, "full cleared");
		dw(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17, "overflow clear");
	endtask
	task automatic t_read();
		logic [7:0] v;
		dw(psp_pkg::REG_DATA_PINS, 8'h5A);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h57, "output full");
		hx(1'b0, 8'h00);
		hr(psp_pkg::HOST_REG_DATA, v);
		check("host byte", 8'h5A, v);
		dr(psp_pkg::REG_STROBE_DIR_STATUS, 8'h17, "output taken");
	endtask
	initial begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_gpio();
		t_refuse();
		t_write();
		t_read();
		close_out();
	end
endmodule

// ===== verif/psp_link_chk.sv
`timescale 1ns/1ps
module psp_link_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] data_pins_oe_n,
	input wire logic [2:0] strobe_pins_oe_n,
	input wire logic host_data_oe_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic cs_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Link framing and drive ownership
	a_host_idle_rst: assert property ($fell(sys_rst) |-> cs_n && rd_n && wr_n && host_data_oe_n)
		else $error("host not idle after reset");
	a_dev_float_rst: assert property ($fell(sys_rst) |-> &data_pins_oe_n && &strobe_pins_oe_n)
		else $error("device drives after reset");
	a_one_strobe: assert property (rd_n || wr_n)
		else $error("read and write strobes low together");
	a_strobe_len: assert property ($fell(cs_n) |-> !cs_n [*5] ##1 cs_n)
		else $error("select low time wrong");
	a_strobe_gap: assert property ($rose(cs_n) |-> cs_n [*2])
		else $error("select idle gap too short");
	a_write_data: assert property (!cs_n && !wr_n |-> !host_data_oe_n)
		else $error("host not driving data in write");
	a_no_clash: assert property (!host_data_oe_n |-> &data_pins_oe_n)
		else $error("both ends drive data bus");
	a_read_drive: assert property ($fell(rd_n) && !cs_n |-> ##[2:5] data_pins_oe_n == 8'h00)
		else $error("device late to drive read data");
	a_read_release: assert property ($rose(rd_n) |-> ##[1:5] &data_pins_oe_n)
		else $error("device holds data bus after read");
	// Traffic seen in both directions
	c_write: cover property ($fell(wr_n) && !cs_n);
	c_read: cover property ($fell(rd_n) && !cs_n);
	c_release: cover property ($rose(cs_n));
endmodule
